// ### inc/sar_adc_defines.svh
`ifndef SAR_ADC_DEFINES_SVH
`define SAR_ADC_DEFINES_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define REG_CLKDIV      12'h000
`define REG_STATUS      12'h004
`define REG_RESULT      12'h008
`define REG_IRQ_STATUS  12'h00c
`define REG_IRQ_MASK    12'h010

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define STAT_DONE_BIT   0
`define STAT_BUSY_BIT   1
`define STAT_EXP_BIT    2
`define STAT_CHAN_LSB   4
`define IRQ_DONE_BIT    0
`define IRQ_ABORT_BIT   1
`define IRQ_WIDTH       2

// ----------------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------------
`define CORE_CLK_HZ     200000000
`define CONV_CLK_HZ     640000
`define CLKDIV_RESET    (`CORE_CLK_HZ / `CONV_CLK_HZ)
`define IRQ_MASK_RESET  2'h0
`define SAR_ITERATIONS  8
`define DONE_LOW_MAX_CONV_CLKS 8

// ----------------------------------------------------------------------------
// ahb-lite encodings
// ----------------------------------------------------------------------------
`define HTRANS_NONSEQ   2'h2
`define HTRANS_SEQ      2'h3
`define HSIZE_WORD      3'h2

`endif

// ### inc/sar_adc_pkg.sv
package sar_adc_pkg;

  // approximation sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ARMED,
    ST_RUN,
    ST_LOAD,
    ST_FLAG
  } sar_state_type;

  typedef logic [7:0] code_type;

endpackage

// ### hw/sync2.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// two-stage synchroniser for pin inputs
// ----------------------------------------------------------------------------
module sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,  // core clock
  input  wire logic             resetn,    // async reset, active low
  input  wire logic [WIDTH-1:0] async_in,  // pin level
  output logic      [WIDTH-1:0] sync_out   // synchronised level
);

  logic [WIDTH-1:0] meta_q;

  initial
  begin
    if (WIDTH < 1)
      $error("sync2: WIDTH must be at least 1");
  end

  // first stage feeds only the second stage
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_q   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

`default_nettype wire

// ### hw/sar_engine.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// successive-approximation sequencer
// ----------------------------------------------------------------------------
module sar_engine
  import sar_adc_pkg::*;
(
  input  wire logic                  core_clk,    // core clock
  input  wire logic                  resetn,      // async reset, active low
  input  wire logic                  conv_tick,   // converter clock enable
  input  wire logic                  start_rise,  // start pulse rising edge
  input  wire logic                  start_fall,  // start pulse falling edge
  input  wire logic                  comp_above,  // input above trial level
  output sar_adc_pkg::code_type      trial_code,  // code driving the ladder
  output sar_adc_pkg::code_type      result,      // output data register
  output logic                       done,        // conversion done level
  output logic                       busy,        // sequence running
  output logic                       aborted      // run abandoned, pulse
);
  import sar_adc_pkg::*;

  sar_state_type state_q;
  logic [2:0]    bit_q;

  assign busy = (state_q == ST_RUN) || (state_q == ST_LOAD) || (state_q == ST_FLAG);

  // sequencer; a start edge takes priority over any tick in the same cycle
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q    <= ST_IDLE;
      bit_q      <= 3'h7;
      trial_code <= 8'h00;
      done       <= 1'b0;
      aborted    <= 1'b0;
    end
    else
    begin
      aborted <= 1'b0;
      if (start_rise)
      begin
        trial_code <= 8'h00;
        done       <= 1'b0;
        aborted    <= busy;
        state_q    <= ST_ARMED;
      end
      else if (start_fall && (state_q == ST_ARMED))
      begin
        bit_q      <= 3'h7;
        trial_code <= 8'h80;
        state_q    <= ST_RUN;
      end
      else if (conv_tick)
      begin
        case (state_q)
          ST_RUN:
          begin
            // keep the trial bit only if the input stays above the tap
            trial_code[bit_q] <= comp_above;
            if (bit_q == 3'h0)
              state_q <= ST_LOAD;
            else
            begin
              trial_code[bit_q - 3'h1] <= 1'b1;
              bit_q                    <= bit_q - 3'h1;
            end
          end
          ST_LOAD:
            state_q <= ST_FLAG;
          ST_FLAG:
          begin
            done    <= 1'b1;
            state_q <= ST_IDLE;
          end
          default:
            state_q <= state_q;
        endcase
      end
    end
  end

  // result register is loaded one converter clock before done rises
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      result <= 8'h00;
    else if (conv_tick && !start_rise && (state_q == ST_LOAD))
      result <= trial_code;
  end

endmodule

`default_nettype wire

// ### hw/sar_adc_mux_control.sv
// Summary of operation
// - select one of sixteen inputs by code
// - latch channel code on strobe rising edge
// - expansion low turns every channel off
// - eight iterations, most significant bit first
// - start rising edge clears approximation register
// - start falling edge begins the approximation
// - new start abandons running conversion
// - done may loop back to start
// - done falls within eight clocks of start
// - result is straight binary, positive true
// - first step at half LSB, then per LSB
// - result loaded one clock before done
`include "sar_adc_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module sar_adc_mux_control
  import sar_adc_pkg::*;
#(
  parameter int DIV_WIDTH = 16
) (
  input  wire logic        core_clk,            // 200 mhz core clock
  input  wire logic        resetn,              // async reset, active low
  // ahb-lite slave
  input  wire logic        hsel,                // slave select
  input  wire logic [11:0] haddr,               // byte address
  input  wire logic [1:0]  htrans,              // transfer type
  input  wire logic        hwrite,              // write not read
  input  wire logic [2:0]  hsize,               // transfer size
  input  wire logic [31:0] hwdata,              // write data
  input  wire logic        hready,              // bus ready
  output logic             hreadyout,           // slave ready
  output logic             hresp,               // always okay
  output logic [31:0]      hrdata,              // read data
  // converter pins
  input  wire logic [3:0]  channel_code,        // d..a channel code
  input  wire logic        addr_latch_strobe,   // channel latch strobe
  input  wire logic        expansion_enable,    // high enables multiplexer
  input  wire logic        conversion_start,    // start pulse
  input  wire logic        output_enable,       // data pin enable
  input  wire logic        comp_above,          // comparator decision
  output logic [15:0]      channel_select,      // one switch per input
  output sar_adc_pkg::code_type ladder_code,    // trial code to ladder
  output logic [7:0]       data_out,            // data pin drive value
  output logic [7:0]       data_oe,             // data pin enables
  output logic             conversion_done,     // end of conversion
  output logic             irq                  // interrupt, level
);
  import sar_adc_pkg::*;

  // --------------------------------------------------------------------------
  // elaboration checks
  // --------------------------------------------------------------------------
  localparam logic [DIV_WIDTH-1:0] CLKDIV_INIT = DIV_WIDTH'(`CLKDIV_RESET);

  initial
  begin
    if (DIV_WIDTH < 2 || DIV_WIDTH > 32)
      $error("sar_adc_mux_control: DIV_WIDTH out of range");
    if (`CLKDIV_RESET >= (64'h1 << DIV_WIDTH))
      $error("sar_adc_mux_control: divider reset value does not fit");
  end

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  logic [3:0] code_s;
  logic       strobe_s;
  logic       exp_s;
  logic       start_s;
  logic       oe_s;
  logic       comp_s;

  sync2 #(
    .WIDTH (9)
  ) u_pin_sync (
    .core_clk (core_clk),
    .resetn   (resetn),
    .async_in ({channel_code, addr_latch_strobe, expansion_enable,
                conversion_start, output_enable, comp_above}),
    .sync_out ({code_s, strobe_s, exp_s, start_s, oe_s, comp_s})
  );

  // edge detection works on the synchronised copies only
  logic strobe_d1_q;
  logic start_d1_q;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      strobe_d1_q <= 1'b0;
      start_d1_q  <= 1'b0;
    end
    else
    begin
      strobe_d1_q <= strobe_s;
      start_d1_q  <= start_s;
    end
  end

  logic strobe_rise;
  logic start_rise;
  logic start_fall;

  assign strobe_rise = strobe_s & ~strobe_d1_q;
  assign start_rise  = start_s & ~start_d1_q;
  assign start_fall  = ~start_s & start_d1_q;

  // --------------------------------------------------------------------------
  // converter clock divider
  // --------------------------------------------------------------------------
  logic [DIV_WIDTH-1:0] clkdiv_q;
  logic [DIV_WIDTH-1:0] div_cnt_q;
  logic                 conv_tick;

  // a divisor of zero behaves like one; tick is a single-cycle enable
  assign conv_tick = (div_cnt_q == '0);

  // a start fall reloads the count so the first trial gets a whole period;
  // the comparator pin is synchronised, so divisors below 3 decide on stale levels
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      div_cnt_q <= '0;
    else if (conv_tick || start_fall)
      div_cnt_q <= (clkdiv_q == '0) ? '0 : clkdiv_q - DIV_WIDTH'(1);
    else
      div_cnt_q <= div_cnt_q - DIV_WIDTH'(1);
  end

  // --------------------------------------------------------------------------
  // multiplexer address latch and decoder
  // --------------------------------------------------------------------------
  logic [3:0] chan_q;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      chan_q <= 4'h0;
    else if (strobe_rise)
      chan_q <= code_s;
  end

  // one registered switch control per analog input
  genvar ch;
  generate
    for (ch = 0; ch < 16; ch++)
    begin : g_chan
      always_ff @(posedge core_clk or negedge resetn)
      begin
        if (!resetn)
          channel_select[ch] <= 1'b0;
        else
          channel_select[ch] <= exp_s && (chan_q == 4'(ch));
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // approximation sequencer
  // --------------------------------------------------------------------------
  code_type result;
  logic     done;
  logic     busy;
  logic     aborted;

  sar_engine u_engine (
    .core_clk   (core_clk),
    .resetn     (resetn),
    .conv_tick  (conv_tick),
    .start_rise (start_rise),
    .start_fall (start_fall),
    .comp_above (comp_s),
    .trial_code (ladder_code),
    .result     (result),
    .done       (done),
    .busy       (busy),
    .aborted    (aborted)
  );

  assign conversion_done = done;

  // detect the done rising edge for the interrupt
  logic done_d1_q;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      done_d1_q <= 1'b0;
    else
      done_d1_q <= done;
  end

  // --------------------------------------------------------------------------
  // data pins
  // --------------------------------------------------------------------------
  // the result register keeps its value while the pins are released
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      data_out <= 8'h00;
      data_oe  <= 8'h00;
    end
    else
    begin
      data_out <= result;
      data_oe  <= {8{oe_s}};
    end
  end

  // --------------------------------------------------------------------------
  // ahb-lite address phase capture
  // --------------------------------------------------------------------------
  logic        wr_pend_q;
  logic [11:0] wr_addr_q;
  logic        accept;
  logic [31:0] rd_val;

  // zero wait states: every transfer completes in its first data cycle
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign accept    = hsel && hready && htrans[1];

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
    end
    else
    begin
      wr_pend_q <= accept && hwrite;
      wr_addr_q <= haddr;
    end
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  logic [`IRQ_WIDTH-1:0] irq_stat_q;
  logic [`IRQ_WIDTH-1:0] irq_mask_q;
  logic [`IRQ_WIDTH-1:0] irq_event;
  logic [`IRQ_WIDTH-1:0] irq_clear;

  assign irq_event = {aborted, done & ~done_d1_q};
  assign irq_clear = (wr_pend_q && wr_addr_q == `REG_IRQ_STATUS) ?
                     hwdata[`IRQ_WIDTH-1:0] : '0;

  // divisor steers the converter clock rate
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      clkdiv_q <= CLKDIV_INIT;
    else if (wr_pend_q && wr_addr_q == `REG_CLKDIV)
      clkdiv_q <= hwdata[DIV_WIDTH-1:0];
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      irq_mask_q <= `IRQ_MASK_RESET;
    else if (wr_pend_q && wr_addr_q == `REG_IRQ_MASK)
      irq_mask_q <= hwdata[`IRQ_WIDTH-1:0];
  end

  // write-one-to-clear; a new event in the clearing cycle survives
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      irq_stat_q <= '0;
    else
      irq_stat_q <= (irq_stat_q & ~irq_clear) | irq_event;
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // read mux, unmapped offsets read as zero
  always_comb
  begin
    rd_val = 32'h0000_0000;
    if (haddr == `REG_CLKDIV)
      rd_val[DIV_WIDTH-1:0] = clkdiv_q;
    else if (haddr == `REG_STATUS)
    begin
      rd_val[`STAT_DONE_BIT]              = done;
      rd_val[`STAT_BUSY_BIT]              = busy;
      rd_val[`STAT_EXP_BIT]               = exp_s;
      rd_val[`STAT_CHAN_LSB +: 4]         = chan_q;
    end
    else if (haddr == `REG_RESULT)
      rd_val[7:0] = result;
    else if (haddr == `REG_IRQ_STATUS)
      rd_val[`IRQ_WIDTH-1:0] = irq_stat_q;
    else if (haddr == `REG_IRQ_MASK)
      rd_val[`IRQ_WIDTH-1:0] = irq_mask_q;
  end

  // read data is registered at the address phase, valid in the data phase
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      hrdata <= 32'h0000_0000;
    else if (accept && !hwrite)
      hrdata <= rd_val;
  end

endmodule

`default_nettype wire

// ### sim/sar_adc_mux_control_asserts.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// pin-level checker for the converter control block
// ----------------------------------------------------------------------------
module sar_adc_mux_control_asserts
  import sar_adc_pkg::*;
(
  input wire logic                  core_clk,          // core clock
  input wire logic                  resetn,            // async reset, active low
  input wire logic                  expansion_enable,  // multiplexer enable pin
  input wire logic                  conversion_start,  // start pin
  input wire logic                  output_enable,     // data pin enable
  input wire logic [15:0]           channel_select,    // switch enables
  input wire sar_adc_pkg::code_type ladder_code,       // trial code
  input wire logic [7:0]            data_out,          // data pin value
  input wire logic [7:0]            data_oe,           // data pin enables
  input wire logic                  conversion_done    // end of conversion
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // pins pass two sync flops and an output register, hence the settle counts
  onehot_sel_a: assert property ($onehot0(channel_select))
    else $error("more than one channel switched on");
  exp_off_a: assert property (!expansion_enable [*5] |-> channel_select == 16'h0000)
    else $error("channel on while expansion low");
  done_low_a: assert property ($rose(conversion_start) |-> ##[1:8] !conversion_done)
    else $error("done not low after start");
  done_hold_a: assert property ($fell(conversion_done) |-> $past(conversion_start, 1) ||
    $past(conversion_start, 2) || $past(conversion_start, 3) || $past(conversion_start, 4))
    else $error("done dropped without start");
  clear_trial_a: assert property ($rose(conversion_start) |-> ##[1:4] ladder_code == 8'h00)
    else $error("trial not cleared on start");
  begin_msb_a: assert property ($fell(conversion_start) |-> ##[1:4] ladder_code == 8'h80)
    else $error("msb trial not set on start fall");
  oe_on_a: assert property (output_enable [*4] |-> data_oe == 8'hff)
    else $error("data pins not driven");
  oe_off_a: assert property (!output_enable [*4] |-> data_oe == 8'h00)
    else $error("data pins not released");
  load_first_a: assert property ($rose(conversion_done) |-> $stable(data_out))
    else $error("result loaded with done");
endmodule

`default_nettype wire

// ### sim/adc_far_end.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// analog side and data bus seen by the host
// ----------------------------------------------------------------------------
module adc_far_end
  import sar_adc_pkg::*;
(
  input  wire logic                  core_clk,        // core clock
  input  wire logic [15:0]           channel_select,  // switch enables
  input  wire sar_adc_pkg::code_type ladder_code,     // trial code
  input  wire logic [7:0]            ext_level,       // external comparator signal
  input  wire logic [7:0]            data_out,        // data pin value
  input  wire logic [7:0]            data_oe,         // data pin enables
  output logic                       comp_above,      // comparator decision
  output logic [7:0]                 data_bus         // resolved data lines
);
  logic [7:0] level;
  logic [7:0] float_q = 8'h55;

  // input k sits at code 17*k; nothing selected leaves the external signal
  always_comb
  begin
    level = ext_level;
    for (int k = 0; k < 16; k++)
      if (channel_select[k]) level = 8'(k * 17);
  end

  // higher input keeps the trial bit, so the result is straight binary
  assign comp_above = (level >= ladder_code);

  // undriven lines toggle so a stale value can never look right
  always @(posedge core_clk) float_q <= ~float_q;
  assign data_bus = (data_oe & data_out) | (~data_oe & float_q);
endmodule

`default_nettype wire

// ### sim/tb_sar_adc_mux_control.sv
`include "sar_adc_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_sar_adc_mux_control;
  import sar_adc_pkg::*;
  logic        core_clk, resetn, hsel, hwrite, hready, hreadyout, hresp;
  logic        addr_latch_strobe, expansion_enable, conversion_start, start_pin;
  logic        free_run, output_enable, comp_above, conversion_done, irq;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [3:0]  channel_code;
  logic [15:0] channel_select;
  code_type    ladder_code;
  logic [7:0]  data_out, data_oe, data_bus, ext_level;
  int          num_errors, checked, cycles, n;

  // ------------------------------------------------------------------------
  // clock, reset, wiring
  // ------------------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // the host pin starts; free run also loops done back onto start
  assign hready = hreadyout;
  assign conversion_start = start_pin | (free_run & conversion_done);

  sar_adc_mux_control dut_u (.core_clk(core_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .channel_code(channel_code),
    .addr_latch_strobe(addr_latch_strobe), .expansion_enable(expansion_enable),
    .conversion_start(conversion_start), .output_enable(output_enable), .comp_above(comp_above),
    .channel_select(channel_select), .ladder_code(ladder_code), .data_out(data_out),
    .data_oe(data_oe), .conversion_done(conversion_done), .irq(irq));

  adc_far_end far_u (.core_clk(core_clk), .channel_select(channel_select), .ladder_code(ladder_code),
    .ext_level(ext_level), .data_out(data_out), .data_oe(data_oe), .comp_above(comp_above),
    .data_bus(data_bus));

  // ------------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------------
  task stop_test;
    if (num_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask

  // one single transfer; read data is taken at the data phase's edge
  task ahb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= `HTRANS_NONSEQ;
    haddr  <= a;
    hwrite <= w;
    hsize  <= `HSIZE_WORD;
    do cyc(1); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do cyc(1); while (hready !== 1'b1);
    rd = hrdata;
    chk(32'(hresp), 32'h0, "okay response");
  endtask

  // code held steady around the strobe edge
  task latch(input logic [3:0] ch);
    channel_code <= ch;
    cyc(2);
    addr_latch_strobe <= 1'b1;
    cyc(3);
    addr_latch_strobe <= 1'b0;
    cyc(4);
  endtask

  // start held high well past the sync delay, as the host must
  task conv;
    start_pin <= 1'b1;
    cyc(6);
    chk(32'(conversion_done), 32'h0, "done still high");
    start_pin <= 1'b0;
    n = 0;
    while (conversion_done !== 1'b1 && n < 400)
    begin
      cyc(1);
      n++;
    end
    chk(32'(n >= 72 && n <= 100), 32'h1, "conversion length");
  endtask

  // ------------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------------
  task t_regs;
    ahb(0, `REG_CLKDIV, 0);
    chk(rd, `CLKDIV_RESET, "divider reset");
    ahb(0, `REG_IRQ_MASK, 0);
    chk(rd, 32'h0, "mask reset");
    ahb(0, 12'h020, 0);
    chk(rd, 32'h0, "unmapped read");
    ahb(1, `REG_RESULT, 32'hff);
    ahb(0, `REG_RESULT, 0);
    chk(rd, 32'h0, "read-only result");
    ahb(1, `REG_CLKDIV, 32'h8);
    ahb(0, `REG_CLKDIV, 0);
    chk(rd, 32'h8, "divider write");
  endtask

  task t_channels;
    for (int ch = 0; ch < 16; ch++)
    begin
      latch(4'(ch));
      chk(32'(channel_select), 32'h1 << ch, "channel select");
      conv();
      ahb(0, `REG_RESULT, 0);
      chk(rd, 32'(ch * 17), "result code");
      output_enable <= 1'b1;
      cyc(4);
      chk(32'(data_bus), 32'(ch * 17), "data pins");
      output_enable <= 1'b0;
      cyc(4);
      chk(32'(data_oe), 32'h0, "pins released");
    end
    channel_code <= 4'h3;
    cyc(6);
    chk(32'(channel_select), 32'h8000, "code without strobe");
  endtask

  task t_expansion;
    expansion_enable <= 1'b0;
    cyc(6);
    chk(32'(channel_select), 32'h0, "all channels off");
    ahb(0, `REG_STATUS, 0);
    chk(rd, (32'hf << `STAT_CHAN_LSB) | (32'h1 << `STAT_DONE_BIT), "status idle");
    conv();
    ahb(0, `REG_RESULT, 0);
    chk(rd, 32'h5a, "external signal");
    expansion_enable <= 1'b1;
    cyc(6);
    chk(32'(channel_select), 32'h8000, "channel back");
  endtask

  // abandon a run mid-way, then check events, mask and clear
  task t_restart;
    ahb(1, `REG_IRQ_STATUS, 32'h3);
    ahb(1, `REG_IRQ_MASK, 32'h3);
    start_pin <= 1'b1;
    cyc(6);
    start_pin <= 1'b0;
    cyc(30);
    ahb(0, `REG_STATUS, 0);
    chk(rd, (32'hf << `STAT_CHAN_LSB) | (32'h1 << `STAT_EXP_BIT) | (32'h1 << `STAT_BUSY_BIT),
        "status busy");
    conv();
    ahb(0, `REG_RESULT, 0);
    chk(rd, 32'hff, "result after restart");
    ahb(0, `REG_IRQ_STATUS, 0);
    chk(rd, 32'h3, "abort and done events");
    chk(32'(irq), 32'h1, "irq raised");
    ahb(1, `REG_IRQ_MASK, 32'h0);
    cyc(1);
    chk(32'(irq), 32'h0, "irq masked");
    ahb(1, `REG_IRQ_MASK, 32'h3);
    ahb(1, `REG_IRQ_STATUS, 32'h3);
    cyc(1);
    chk(32'(irq), 32'h0, "irq cleared");
  endtask

  task t_freerun;
    int   rises;
    logic last;
    rises = 0;
    last = conversion_done;
    free_run <= 1'b1;
    repeat (400)
    begin
      cyc(1);
      if (conversion_done === 1'b1 && last !== 1'b1) rises++;
      last = conversion_done;
    end
    while (conversion_done !== 1'b0) cyc(1);
    free_run <= 1'b0;
    chk(32'(rises >= 3), 32'h1, "free running");
  endtask

  // ------------------------------------------------------------------------
  // main sequence and hang guard
  // ------------------------------------------------------------------------
  initial
  begin
    {resetn, hsel, hwrite, addr_latch_strobe, start_pin, free_run, output_enable} = '0;
    {haddr, htrans, hsize, hwdata, channel_code} = '0;
    expansion_enable = 1'b1;
    ext_level = 8'h5a;
    num_errors = 0;
    checked = 0;
    cycles = 0;
    cyc(2);
    resetn <= 1'b1;
    cyc(1);
    t_regs();
    t_channels();
    t_expansion();
    t_restart();
    t_freerun();
    stop_test();
  end

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      stop_test();
    end
  end
endmodule

bind sar_adc_mux_control sar_adc_mux_control_asserts chk_u (.core_clk(core_clk), .resetn(resetn),
  .expansion_enable(expansion_enable), .conversion_start(conversion_start),
  .output_enable(output_enable), .channel_select(channel_select), .ladder_code(ladder_code),
  .data_out(data_out), .data_oe(data_oe), .conversion_done(conversion_done));

`default_nettype wire
